//--- rtl/srb_response_builder.sv
// sensor reading response builder with apb registers and byte stream output
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module srb_response_builder (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // apb slave
    input wire srb_pkg::srb_apb_req_t apb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // sampler side
    input wire logic sample_valid_in,
    input wire logic [31:0] sample_value_in,
    input wire logic [7:0] sample_level_in,
    output logic sample_req_out,
    // response byte stream
    output logic [7:0] resp_byte_out,
    output logic resp_valid_out,
    output logic resp_last_out,
    input wire logic resp_ready_in,
    // interrupt
    output logic irq_out
);
    import srb_pkg::*;

    // register and sensor state
    logic [2:0] run_q, run_d;
    logic [2:0] width_q, width_d;
    logic policy_q, policy_d;
    srb_levels_t lvl_q, lvl_d;
    logic [31:0] meas_q, meas_d;
    logic [SRB_IRQ_W-1:0] irq_stat_q, irq_stat_d;
    logic [SRB_IRQ_W-1:0] irq_mask_q, irq_mask_d;
    logic [SRB_IRQ_W-1:0] irq_set;
    logic enabled;
    logic acc_wr;
    logic acc_rd;
    logic map_hit;
    logic start_req;
    logic level_ok;
    // response engine state
    srb_state_t st_q, st_d;
    srb_resp_t snap_q, snap_d;
    logic [2:0] idx_q, idx_d;
    logic [7:0] byte_q, byte_d;
    logic valid_q, valid_d;
    logic last_q, last_d;
    logic req_q, req_d;

    // saturate the raw signed sample into the selected format
    function automatic logic [31:0] srb_fmt(input logic [31:0] raw, input logic [2:0] code);
        logic signed [32:0] v;
        logic signed [32:0] lo;
        logic signed [32:0] hi;
        v = {raw[31], raw};
        lo = 33'sh1_0000_0000;
        hi = 33'sh0_7fff_ffff;
        case (code)
            SRB_W_U8: begin
                lo = 33'sh0_0000_0000;
                hi = 33'sh0_0000_00ff;
            end
            SRB_W_S8: begin
                lo = -33'sh0_0000_0080;
                hi = 33'sh0_0000_007f;
            end
            SRB_W_U16: begin
                lo = 33'sh0_0000_0000;
                hi = 33'sh0_0000_ffff;
            end
            SRB_W_S16: begin
                lo = -33'sh0_0000_8000;
                hi = 33'sh0_0000_7fff;
            end
            SRB_W_U32: begin
                lo = 33'sh0_0000_0000;
            end
            default: begin
            end
        endcase
        if (v < lo) begin
            v = lo;
        end else if (v > hi) begin
            v = hi;
        end
        return v[31:0];
    endfunction : srb_fmt

    // index of the last measurement byte for a width code
    function automatic logic [2:0] srb_last_idx(input logic [2:0] code);
        logic [2:0] r;
        case (code)
            SRB_W_U8, SRB_W_S8: r = SRB_IDX_MEAS;
            SRB_W_U16, SRB_W_S16: r = SRB_IDX_MEAS + 3'h1;
            // spare codes send four bytes, matching their s32 saturation
            default: r = SRB_IDX_MEAS + 3'h3;
        endcase
        return r;
    endfunction : srb_last_idx

    // byte of a snapshot at a response index
    function automatic logic [7:0] srb_byte(input srb_resp_t s, input logic [2:0] i);
        logic [7:0] b;
        case (i)
            SRB_IDX_CUR: b = s.lvl.current;
            SRB_IDX_PRIOR: b = s.lvl.prior;
            SRB_IDX_EVENT: b = s.lvl.event_lvl;
            SRB_IDX_MEAS: b = s.meas[7:0];
            3'h4: b = s.meas[15:8];
            3'h5: b = s.meas[23:16];
            3'h6: b = s.meas[31:24];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : srb_byte

    assign enabled = (run_q == SRB_RUN_ENABLED);
    assign acc_wr = apb_in.psel && apb_in.penable && apb_in.pwrite;
    assign acc_rd = apb_in.psel && apb_in.penable && !apb_in.pwrite;
    assign level_ok = (sample_level_in != SRB_LVL_UNKNOWN) && (sample_level_in <= SRB_LVL_MAX);
    assign start_req = acc_wr && (apb_in.paddr == SRB_OFS_CMD) && apb_in.pwdata[0];

    always_comb begin
        case (apb_in.paddr)
            SRB_OFS_CTRL, SRB_OFS_CMD, SRB_OFS_STAT,
            SRB_OFS_MEAS, SRB_OFS_IRQ_STAT, SRB_OFS_IRQ_MASK: map_hit = 1'b1;
            default: map_hit = 1'b0;
        endcase
    end

    // zero wait states; unmapped addresses answer with an error
    assign pready_out = 1'b1;
    assign pslverr_out = apb_in.psel && apb_in.penable && !map_hit;

    always_comb begin
        prdata_out = 32'h0000_0000;
        if (acc_rd) begin
            case (apb_in.paddr)
                SRB_OFS_CTRL: begin
                    prdata_out[SRB_CTRL_RUN_LSB +: 3] = run_q;
                    prdata_out[SRB_CTRL_WIDTH_LSB +: 3] = width_q;
                    prdata_out[SRB_CTRL_POLICY_BIT] = policy_q;
                end
                SRB_OFS_STAT: begin
                    // current level in the low byte, event level on top
                    prdata_out[23:0] = {lvl_q.event_lvl, lvl_q.prior, lvl_q.current};
                    prdata_out[SRB_STAT_BUSY_BIT] = (st_q != SRB_ST_IDLE);
                end
                SRB_OFS_MEAS: prdata_out = meas_q;
                SRB_OFS_IRQ_STAT: prdata_out[SRB_IRQ_W-1:0] = irq_stat_q;
                SRB_OFS_IRQ_MASK: prdata_out[SRB_IRQ_W-1:0] = irq_mask_q;
                default: prdata_out = 32'h0000_0000;
            endcase
        end
    end

    // sensor state and register next values
    always_comb begin
        run_d = run_q;
        width_d = width_q;
        policy_d = policy_q;
        irq_mask_d = irq_mask_q;
        lvl_d = lvl_q;
        meas_d = meas_q;
        irq_set = '0;
        if (acc_wr && apb_in.paddr == SRB_OFS_CTRL) begin
            run_d = apb_in.pwdata[SRB_CTRL_RUN_LSB +: 3];
            width_d = apb_in.pwdata[SRB_CTRL_WIDTH_LSB +: 3];
            policy_d = apb_in.pwdata[SRB_CTRL_POLICY_BIT];
        end
        if (acc_wr && apb_in.paddr == SRB_OFS_IRQ_MASK) begin
            irq_mask_d = apb_in.pwdata[SRB_IRQ_W-1:0];
        end
        if (!enabled) begin
            // any state but enabled wipes what was assessed
            lvl_d.current = SRB_LVL_UNKNOWN;
            lvl_d.prior = SRB_LVL_UNKNOWN;
            lvl_d.event_lvl = SRB_LVL_UNKNOWN;
        end else if (sample_valid_in) begin
            meas_d = sample_value_in;
            // an unknown or out of range assessment is dropped, keeping the last known level
            if (level_ok) begin
                if (lvl_q.current == SRB_LVL_UNKNOWN) begin
                    lvl_d.prior = sample_level_in;
                end else if (sample_level_in != lvl_q.current) begin
                    lvl_d.prior = lvl_q.current;
                end
                lvl_d.current = sample_level_in;
                if (sample_level_in != lvl_q.current) begin
                    irq_set[SRB_IRQ_LEVEL] = 1'b1;
                end
                // latch a crossing, or the first assessment after enabling
                if (lvl_q.event_lvl == SRB_LVL_UNKNOWN ||
                    (sample_level_in != SRB_LVL_NORMAL &&
                     sample_level_in != lvl_q.event_lvl)) begin
                    lvl_d.event_lvl = sample_level_in;
                    irq_set[SRB_IRQ_EVENT] = (sample_level_in != SRB_LVL_NORMAL);
                end
            end
        end
        irq_set[SRB_IRQ_DONE] = valid_q && resp_ready_in && last_q;
        irq_stat_d = irq_stat_q;
        if (acc_wr && apb_in.paddr == SRB_OFS_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~apb_in.pwdata[SRB_IRQ_W-1:0];
        end
        // set wins over a clear in the same cycle
        irq_stat_d = irq_stat_d | irq_set;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            run_q <= SRB_RUN_RESET;
            width_q <= SRB_W_U8;
            policy_q <= 1'b0;
            irq_mask_q <= '0;
            irq_stat_q <= '0;
            lvl_q <= '0;
            meas_q <= 32'h0000_0000;
        end else begin
            run_q <= run_d;
            width_q <= width_d;
            policy_q <= policy_d;
            irq_mask_q <= irq_mask_d;
            irq_stat_q <= irq_stat_d;
            lvl_q <= lvl_d;
            meas_q <= meas_d;
        end
    end

    assign irq_out = |(irq_stat_q & irq_mask_q);

    // response engine next values
    always_comb begin
        st_d = st_q;
        snap_d = snap_q;
        idx_d = idx_q;
        byte_d = byte_q;
        valid_d = valid_q;
        last_d = last_q;
        req_d = 1'b0;
        case (st_q)
            SRB_ST_IDLE: begin
                if (start_req) begin
                    // on-request policy asks for a fresh sample first while enabled
                    if (policy_q && enabled) begin
                        st_d = SRB_ST_WAIT;
                        req_d = 1'b1;
                    end else begin
                        st_d = SRB_ST_SEND;
                        snap_d.lvl = lvl_q;
                        snap_d.meas = srb_fmt(meas_q, width_q);
                        snap_d.last_idx = srb_last_idx(width_q);
                        if (lvl_q.current == SRB_LVL_UNKNOWN) begin
                            snap_d.meas = 32'h0000_0000;
                        end
                        idx_d = SRB_IDX_CUR;
                        byte_d = lvl_q.current;
                        valid_d = 1'b1;
                        last_d = 1'b0;
                    end
                end
            end
            SRB_ST_WAIT: begin
                // leaving enabled aborts the wait and sends unknown levels
                if (sample_valid_in || !enabled) begin
                    st_d = SRB_ST_IDLE;
                end
            end
            SRB_ST_SEND: begin
                if (resp_ready_in) begin
                    if (last_q) begin
                        st_d = SRB_ST_IDLE;
                        valid_d = 1'b0;
                        last_d = 1'b0;
                    end else begin
                        idx_d = idx_q + 3'h1;
                        byte_d = srb_byte(snap_q, idx_d);
                        last_d = (idx_d == snap_q.last_idx);
                    end
                end
            end
            default: begin
                st_d = SRB_ST_IDLE;
                valid_d = 1'b0;
                last_d = 1'b0;
            end
        endcase
    end

    // a sample answering the on-request policy re-enters idle with a pending start
    logic pend_q, pend_d;
    always_comb begin
        pend_d = pend_q;
        if (st_q == SRB_ST_WAIT && st_d == SRB_ST_IDLE) begin
            pend_d = 1'b1;
        end else if (st_q == SRB_ST_IDLE) begin
            pend_d = 1'b0;
        end
    end

    srb_state_t st_n;
    srb_resp_t snap_n;
    logic [2:0] idx_n;
    logic [7:0] byte_n;
    logic valid_n;
    logic last_n;
    always_comb begin
        st_n = st_d;
        snap_n = snap_d;
        idx_n = idx_d;
        byte_n = byte_d;
        valid_n = valid_d;
        last_n = last_d;
        // sampled value and levels land in the same edge, so snapshot them next cycle
        if (pend_q && st_q == SRB_ST_IDLE) begin
            st_n = SRB_ST_SEND;
            snap_n.lvl = lvl_q;
            snap_n.meas = srb_fmt(meas_q, width_q);
            snap_n.last_idx = srb_last_idx(width_q);
            if (lvl_q.current == SRB_LVL_UNKNOWN) begin
                snap_n.meas = 32'h0000_0000;
            end
            idx_n = SRB_IDX_CUR;
            byte_n = lvl_q.current;
            valid_n = 1'b1;
            last_n = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            st_q <= SRB_ST_IDLE;
            snap_q <= '0;
            idx_q <= SRB_IDX_CUR;
            byte_q <= 8'h00;
            valid_q <= 1'b0;
            last_q <= 1'b0;
            req_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            st_q <= st_n;
            snap_q <= snap_n;
            idx_q <= idx_n;
            byte_q <= byte_n;
            valid_q <= valid_n;
            last_q <= last_n;
            req_q <= req_d;
            pend_q <= pend_d;
        end
    end

    assign sample_req_out = req_q;
    assign resp_byte_out = byte_q;
    assign resp_valid_out = valid_q;
    assign resp_last_out = last_q;
endmodule : srb_response_builder

//--- rtl/srb_pkg.sv
// package: constants and types for the sensor reading response builder
package srb_pkg;
    // health level enumeration, 8 bits on the wire
    localparam logic [7:0] SRB_LVL_UNKNOWN = 8'h00;
    localparam logic [7:0] SRB_LVL_NORMAL = 8'h01;
    localparam logic [7:0] SRB_LVL_MAX = 8'h0a;
    // run condition codes
    localparam logic [2:0] SRB_RUN_ENABLED = 3'h0;
    // measurement width codes
    localparam logic [2:0] SRB_W_U8 = 3'h0;
    localparam logic [2:0] SRB_W_S8 = 3'h1;
    localparam logic [2:0] SRB_W_U16 = 3'h2;
    localparam logic [2:0] SRB_W_S16 = 3'h3;
    localparam logic [2:0] SRB_W_U32 = 3'h4;
    localparam logic [2:0] SRB_W_S32 = 3'h5;
    // register byte offsets
    localparam logic [7:0] SRB_OFS_CTRL = 8'h00;
    localparam logic [7:0] SRB_OFS_CMD = 8'h04;
    localparam logic [7:0] SRB_OFS_STAT = 8'h08;
    localparam logic [7:0] SRB_OFS_MEAS = 8'h0c;
    localparam logic [7:0] SRB_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] SRB_OFS_IRQ_MASK = 8'h14;
    // control and status field positions, and the reset run code
    localparam int SRB_CTRL_RUN_LSB = 0;
    localparam int SRB_CTRL_WIDTH_LSB = 4;
    localparam int SRB_CTRL_POLICY_BIT = 8;
    localparam int SRB_STAT_BUSY_BIT = 24;
    localparam logic [2:0] SRB_RUN_RESET = 3'h1;
    // interrupt bits
    localparam int SRB_IRQ_W = 3;
    localparam int SRB_IRQ_LEVEL = 0;
    localparam int SRB_IRQ_EVENT = 1;
    localparam int SRB_IRQ_DONE = 2;
    // response layout
    localparam logic [2:0] SRB_IDX_CUR = 3'h0;
    localparam logic [2:0] SRB_IDX_PRIOR = 3'h1;
    localparam logic [2:0] SRB_IDX_EVENT = 3'h2;
    localparam logic [2:0] SRB_IDX_MEAS = 3'h3;

    typedef struct packed {
        logic [7:0] current;
        logic [7:0] prior;
        logic [7:0] event_lvl;
    } srb_levels_t;

    typedef struct packed {
        srb_levels_t lvl;
        logic [31:0] meas;
        logic [2:0] last_idx;
    } srb_resp_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } srb_apb_req_t;

    typedef enum logic [2:0] {
        SRB_ST_IDLE = 3'b001,
        SRB_ST_WAIT = 3'b010,
        SRB_ST_SEND = 3'b100
    } srb_state_t;
endpackage : srb_pkg

//--- bench/srb_sampler_model.sv
// partner model: sampler and response consumer
`timescale 1ns/1ps
module srb_sampler_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // bench controls
    input wire logic push_in,
    input wire logic [31:0] val_in,
    input wire logic [7:0] lvl_in,
    input wire logic [3:0] dly_in,
    // sampler side
    input wire logic req_in,
    output logic valid_out = 1'b0,
    output logic [31:0] value_out = 32'h0,
    output logic [7:0] level_out = 8'h0,
    // response stream
    input wire logic [7:0] byte_in,
    input wire logic bvalid_in,
    output logic ready_out = 1'b0
);
    logic [3:0] dly = 4'h0;
    logic [1:0] ph = 2'h0;
    logic [7:0] got [0:255];
    int n = 0;
    always @(posedge clk_in) begin
        ph <= ph + 2'h1;
        // stalls one cycle in four to exercise the hold
        ready_out <= ph != 2'h1;
        valid_out <= 1'b0;
        // lines are not held outside a pulse
        value_out <= ~value_out;
        level_out <= ~level_out;
        dly <= req_in ? dly_in : (dly != 4'h0 ? dly - 4'h1 : 4'h0);
        if (push_in || dly == 4'h1) begin
            valid_out <= 1'b1;
            value_out <= val_in;
            level_out <= lvl_in;
        end
        // bytes kept raw; the bench checks them against the expected frames
        if (bvalid_in && ready_out) begin
            got[n] <= byte_in;
            n <= n + 1;
        end
        if (!rstn_in) begin
            dly <= 4'h0;
            valid_out <= 1'b0;
        end
    end
endmodule : srb_sampler_model

//--- bench/srb_response_builder_assertions.sv
// checker: port-level assertions for the response builder
`timescale 1ns/1ps
module srb_response_builder_assertions (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // apb
    input wire srb_pkg::srb_apb_req_t apb_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // sampler
    input wire logic sample_valid_in,
    input wire logic [31:0] sample_value_in,
    input wire logic [7:0] sample_level_in,
    input wire logic sample_req_out,
    // stream and interrupt
    input wire logic [7:0] resp_byte_out,
    input wire logic resp_valid_out,
    input wire logic resp_last_out,
    input wire logic resp_ready_in,
    input wire logic irq_out
);
    import srb_pkg::*;
    logic on_q, on_d, seen_q, seen_d;
    logic [2:0] w_q, w_d, cnt_q, cnt_d;
    logic [7:0] cur_q, cur_d;
    wire acc = apb_in.psel && apb_in.penable && pready_out;
    wire ctrl_wr = acc && apb_in.pwrite && apb_in.paddr == SRB_OFS_CTRL;
    wire take = resp_valid_out && resp_ready_in;
    wire [2:0] nb = w_q < 3'h2 ? 3'h1 : (w_q < 3'h4 ? 3'h2 : 3'h4);
    always_comb begin
        {on_d, seen_d, w_d, cnt_d, cur_d} = {on_q, seen_q, w_q, cnt_q, cur_q};
        if (sample_valid_in && on_q && sample_level_in != 8'h0 && sample_level_in <= SRB_LVL_MAX)
            seen_d = 1'b1;
        if (ctrl_wr) begin
            on_d = apb_in.pwdata[2:0] == SRB_RUN_ENABLED;
            w_d = apb_in.pwdata[6:4];
            seen_d = seen_d && on_d;
        end
        if (take) begin
            cnt_d = resp_last_out ? 3'h0 : cnt_q + 3'h1;
            cur_d = cnt_q == 3'h0 ? resp_byte_out : cur_q;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) {on_q, seen_q, w_q, cnt_q, cur_q} <= '0;
        else {on_q, seen_q, w_q, cnt_q, cur_q} <= {on_d, seen_d, w_d, cnt_d, cur_d};
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_stat_read;
        acc && !apb_in.pwrite && apb_in.paddr == SRB_OFS_STAT;
    endsequence
    sequence s_last_take;
        take && resp_last_out;
    endsequence
    a_lvl_range: assert property (s_stat_read |-> prdata_out[7:0] <= SRB_LVL_MAX &&
        prdata_out[15:8] <= SRB_LVL_MAX && prdata_out[23:16] <= SRB_LVL_MAX)
        else $error("level code out of range");
    a_off_unknown: assert property ((s_stat_read and !on_q) |->
        prdata_out[23:0] == 24'h0)
        else $error("levels known while not enabled");
    a_on_known: assert property ((s_stat_read and seen_q) |->
        prdata_out[7:0] != 8'h0 && prdata_out[15:8] != 8'h0 && prdata_out[23:16] != 8'h0)
        else $error("unknown level after assessment");
    a_byte_hold: assert property (resp_valid_out && !resp_ready_in |=>
        resp_valid_out && $stable(resp_byte_out) && $stable(resp_last_out))
        else $error("offered byte changed before acceptance");
    a_frame_len: assert property (s_last_take |-> cnt_q == 3'h2 + nb)
        else $error("frame length wrong for width code");
    a_last_ends: assert property (s_last_take |=> !resp_valid_out [*2])
        else $error("stream continued after last byte");
    a_meas_blank: assert property (take && cnt_q > 3'h2 && cur_q == 8'h0 |->
        resp_byte_out == 8'h0)
        else $error("measurement sent while level unknown");
    a_req_pulse: assert property ($rose(sample_req_out) |=> !sample_req_out)
        else $error("sample request longer than one cycle");
    a_bad_addr: assert property (acc && apb_in.paddr > SRB_OFS_IRQ_MASK |->
        pslverr_out && prdata_out == 32'h0)
        else $error("unmapped access not refused");
endmodule : srb_response_builder_assertions
bind srb_response_builder srb_response_builder_assertions chk (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .apb_in(apb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sample_valid_in(sample_valid_in),
    .sample_value_in(sample_value_in), .sample_level_in(sample_level_in),
    .sample_req_out(sample_req_out), .resp_byte_out(resp_byte_out),
    .resp_valid_out(resp_valid_out), .resp_last_out(resp_last_out),
    .resp_ready_in(resp_ready_in), .irq_out(irq_out));

//--- bench/srb_response_builder_bench.sv
// bench: randomised self-checking run of the response builder
`timescale 1ns/1ps
module srb_response_builder_bench;
    import srb_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    srb_apb_req_t apb_in = '0;
    logic [31:0] prdata_out, sample_value_in, rd, pval = 32'h0, seed = 32'h3b9f;
    logic pready_out, pslverr_out, sample_valid_in, sample_req_out, err, push = 1'b0;
    logic [7:0] sample_level_in, resp_byte_out, plvl = 8'h0;
    logic resp_valid_out, resp_last_out, resp_ready_in, irq_out;
    logic [3:0] pdly = 4'h1;
    int mismatches = 0, n_compared = 0;
    always #5 ref_clk_in = ~ref_clk_in;
    srb_response_builder DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .apb_in(apb_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .sample_valid_in(sample_valid_in), .sample_value_in(sample_value_in),
        .sample_level_in(sample_level_in), .sample_req_out(sample_req_out),
        .resp_byte_out(resp_byte_out), .resp_valid_out(resp_valid_out),
        .resp_last_out(resp_last_out), .resp_ready_in(resp_ready_in), .irq_out(irq_out));
    srb_sampler_model mdl (.clk_in(ref_clk_in), .rstn_in(rstn_in), .push_in(push),
        .val_in(pval), .lvl_in(plvl), .dly_in(pdly), .req_in(sample_req_out),
        .valid_out(sample_valid_in), .value_out(sample_value_in), .level_out(sample_level_in),
        .byte_in(resp_byte_out), .bvalid_in(resp_valid_out), .ready_out(resp_ready_in));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [31:0] fit(logic signed [31:0] s, logic [2:0] w);
        case (w)
            3'h0: return s[31] ? 32'h0 : (s > 32'sh0ff ? 32'h0ff : s);
            3'h1: return s < 32'shffffff80 ? 32'hffffff80 : (s > 32'sh07f ? 32'h07f : s);
            3'h2: return s[31] ? 32'h0 : (s > 32'sh0ffff ? 32'h0ffff : s);
            3'h3: return s < 32'shffff8000 ? 32'hffff8000 : (s > 32'sh07fff ? 32'h07fff : s);
            3'h4: return s[31] ? 32'h0 : s;
            default: return s;
        endcase
    endfunction : fit
    function automatic int nb(logic [2:0] w);
        return w < 3'h2 ? 1 : (w < 3'h4 ? 2 : 4);
    endfunction : nb
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk_in);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk_in);
        apb_in.penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        apb_in <= '0;
        #1;
    endtask : apb
    task automatic smp(logic [31:0] v, logic [7:0] l);
        @(posedge ref_clk_in);
        {pval, plvl, push} <= {v, l, 1'b1};
        @(posedge ref_clk_in);
        push <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask : smp
    task automatic frame(logic [7:0] c, logic [7:0] p, logic [7:0] e, logic [31:0] m,
            logic [2:0] w);
        int n0 = mdl.n;
        int lim = 0;
        apb(1'b1, SRB_OFS_CMD, 32'h1);
        while (mdl.n < n0 + 3 + nb(w) && lim < 300) begin
            @(posedge ref_clk_in);
            lim++;
        end
        if (mdl.n < n0 + 3 + nb(w)) mismatches++;
        chk(32'(mdl.got[n0]), 32'(c));
        chk(32'(mdl.got[n0 + 1]), 32'(p));
        chk(32'(mdl.got[n0 + 2]), 32'(e));
        for (int k = 0; k < nb(w); k++) chk(32'(mdl.got[n0 + 3 + k]), 32'(m[8 * k +: 8]));
    endtask : frame
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        mismatches++;
        test_done();
    end
    initial begin
        logic [31:0] v;
        logic [7:0] l, l2;
        repeat (12) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        apb(1'b0, SRB_OFS_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            v = xs();
            l = 8'h1 + 8'(xs() % 10);
            l2 = 8'h2 + 8'(xs() % 9);
            apb(1'b1, SRB_OFS_CTRL, {25'h0, 3'(i), 4'h0});
            smp(xs(), l);
            apb(1'b0, SRB_OFS_STAT, 32'h0);
            chk(rd, {8'h0, l, l, l});
            smp(v, l2);
            // out-of-range code must leave the levels alone
            smp(v, 8'h0b);
            apb(1'b0, SRB_OFS_STAT, 32'h0);
            chk(rd, {8'h0, l2, l, l2});
            apb(1'b0, SRB_OFS_MEAS, 32'h0);
            chk(rd, v);
            frame(l2, l, l2, fit(v, 3'(i)), 3'(i));
            // a normal level moves current and prior but leaves the latched event
            smp(v, SRB_LVL_NORMAL);
            apb(1'b0, SRB_OFS_STAT, 32'h0);
            chk(rd, {8'h0, l2, l2, SRB_LVL_NORMAL});
            // keep the width code so the blank frame has the expected length
            apb(1'b1, SRB_OFS_CTRL, {25'h0, 3'(i), 1'b0, 3'(i + 1)});
            apb(1'b0, SRB_OFS_STAT, 32'h0);
            chk(rd, 32'h0);
            frame(8'h0, 8'h0, 8'h0, 32'h0, 3'(i));
        end
        apb(1'b1, SRB_OFS_CTRL, 32'h160);
        pdly <= 4'h1 + 4'(xs() % 8);
        {pval, plvl} <= {v, l};
        frame(l, l, l, fit(v, 3'h6), 3'h6);
        apb(1'b1, SRB_OFS_CTRL, 32'h7);
        apb(1'b0, SRB_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h7);
        chk({31'h0, irq_out}, 32'h0);
        apb(1'b1, SRB_OFS_IRQ_MASK, 32'h7);
        chk({31'h0, irq_out}, 32'h1);
        apb(1'b1, SRB_OFS_IRQ_STAT, 32'h7);
        apb(1'b0, SRB_OFS_IRQ_STAT, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        test_done();
    end
endmodule : srb_response_builder_bench
